/* File: logic/sld_driver.sv */
// Twelve-channel serial-in, parallel-out open-drain sink driver core and its latch FIFO.
// Assumes all host pins are asynchronous and sampled by the 100 MHz clock.
// Notes on behaviour
// R1 - A 12-bit shift chain feeds a 12-bit storage register, one bit per channel.
// R2 - Shift clock rise shifts data in; latch clock rise captures the whole chain.
// R3 - Storage reaches output buffers only while clear_n is high.
// R4 - Clear low forces shift chain, storage and all other state to zero; code keeps synchronisers and edge history.
// R5 - Host should hold clear low during power-up or initialisation.
// R6 - Serial output shows last stage, updated only on falling shift clock edge.
// R7 - Cascade by chaining serial out to next serial in, sharing shift clock.
// R8 - Output enable high forces buffers low and every drain off.
// R9 - Output enable low makes buffers follow storage without extra clocking.
// R10 - Buffer bit one turns its drain on to sink; zero turns it off.
// R11 - With enable low and clear high, drains change at latch clock rise.
// R12 - Host may pulse output enable as PWM to dim all channels.
// R13 - Over-temperature indication forces every drain open.
// R14 - Drains resume normal operation once over-temperature clears.
// R15 - Clear acts at once, overriding both shift and latch clocking.
`timescale 1ns/1ps
module sld_driver (
    input  wire logic                   clk,
    input  wire logic                   arst_n,
    input  wire logic                   shiftClock,
    input  wire logic                   latchClock,
    input  wire logic                   clearN,
    input  wire logic                   serialDataIn,
    input  wire logic                   outEnableN,
    input  wire logic                   overTemp,
    output logic                        cascadeDataOut,
    output sld_pkg::sld_chan_type       drainOn,
    output logic                        fifoFull
);
    typedef struct packed {
        sld_pkg::sld_pins_type  sync1;
        sld_pkg::sld_pins_type  sync2;
        logic                   shiftPrev;
        logic                   latchPrev;
        sld_pkg::sld_chan_type  chain;
        sld_pkg::sld_chan_type  storage;
        logic                   cascade_data_out;
        sld_pkg::sld_chan_type  drain;
        logic                   full;
    } sld_state_type;

    sld_state_type         st_q;
    sld_state_type         st_d;
    sld_pkg::sld_pins_type pinsRaw;
    sld_pkg::sld_pins_type pins;
    logic                  shiftRise;
    logic                  shiftFall;
    logic                  latchRise;
    logic                  fifoInReady;
    sld_pkg::sld_chan_type fifoOutData;
    logic                  fifoOutValid;

    assign pinsRaw   = '{shiftClock, latchClock, clearN, serialDataIn, outEnableN, overTemp};
    assign pins      = st_q.sync2;
    assign shiftRise = pins.shiftClock && !st_q.shiftPrev;
    assign shiftFall = !pins.shiftClock && st_q.shiftPrev;
    assign latchRise = pins.latchClock && !st_q.latchPrev;

    // Latched words queue here so that the latch capture is decoupled from the storage update.
    sld_fifo #(
        .Width (sld_pkg::ChanCount),
        .Depth (sld_pkg::FifoDepth)
    ) uFifo (
        .clk      (clk),
        .arst_n   (arst_n),
        .flush    (!pins.clearN),
        .inData   (st_q.chain),
        .inValid  (latchRise && pins.clearN),
        .inReady  (fifoInReady),
        .outData  (fifoOutData),
        .outValid (fifoOutValid),
        .outReady (1'h1)
    );

    always_comb begin
        st_d           = st_q;
        st_d.sync1     = pinsRaw;
        st_d.sync2     = st_q.sync1;
        st_d.shiftPrev = pins.shiftClock;
        st_d.latchPrev = pins.latchClock;
        st_d.full      = !fifoInReady;
        if (!pins.clearN) begin
            // Clear is seen after the synchroniser, so it acts within three clock cycles.
            st_d.chain   = sld_pkg::ChainReset; // [R4] [R15]
            st_d.storage = sld_pkg::ChainReset; // [R4]
            st_d.cascade_data_out  = 1'h0;                // [R4]
        end else begin
            if (shiftRise) begin
                st_d.chain = {st_q.chain[sld_pkg::ChanCount-2:0], pins.serialDataIn}; // [R1] [R2]
            end
            if (shiftFall) begin
                st_d.cascade_data_out = st_q.chain[sld_pkg::ChanCount-1]; // [R6] [R7]
            end
            if (fifoOutValid) begin
                st_d.storage = fifoOutData; // [R2] [R11]
            end
        end
        // Gate order: clear, enable, thermal; any one opens every drain.
        if (!pins.clearN || pins.outEnableN || pins.overTemp) begin
            st_d.drain = sld_pkg::ChainReset; // [R3] [R8] [R13] [R12]
        end else begin
            st_d.drain = st_d.storage; // [R9] [R10] [R14]
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign cascadeDataOut = st_q.cascade_data_out;
    assign drainOn        = st_q.drain;
    assign fifoFull       = st_q.full;

    sequence latchEdge_s;
        latchRise && pins.clearN && !pins.outEnableN && !pins.overTemp;
    endsequence

    chainShift_a: assert property (@(posedge clk) disable iff (!arst_n) // [R2]
        shiftRise && pins.clearN |=> st_q.chain[0] == $past(pins.serialDataIn))
        else $error("Shift chain did not take serial input.");
    serOutFall_a: assert property (@(posedge clk) disable iff (!arst_n) // [R6]
        $changed(st_q.cascade_data_out) && $past(pins.clearN) |-> $past(shiftFall))
        else $error("Serial out changed off a falling shift edge.");
    clearChain_a: assert property (@(posedge clk) disable iff (!arst_n) // [R4]
        !pins.clearN |=> st_q.chain == '0 && st_q.storage == '0)
        else $error("Clear did not zero the registers.");
    clearDrain_a: assert property (@(posedge clk) disable iff (!arst_n) // [R3]
        !pins.clearN |=> drainOn == '0)
        else $error("Drain on while clear low.");
    enableOff_a: assert property (@(posedge clk) disable iff (!arst_n) // [R8]
        pins.outEnableN |=> drainOn == '0)
        else $error("Drain on while outputs disabled.");
    thermalOff_a: assert property (@(posedge clk) disable iff (!arst_n) // [R13]
        pins.overTemp |=> drainOn == '0)
        else $error("Drain on during over-temperature.");
    followStore_a: assert property (@(posedge clk) disable iff (!arst_n) // [R9]
        pins.clearN && !pins.outEnableN && !pins.overTemp |=> drainOn == st_q.storage)
        else $error("Drains do not follow storage.");
    latchDrain_a: assert property (@(posedge clk) disable iff (!arst_n) // [R11]
        latchEdge_s ##1 (pins.clearN && !pins.outEnableN && !pins.overTemp)[*2]
        |=> drainOn == $past(st_q.chain, 3))
        else $error("Drains did not take latched word.");

    sequence thermalEnd_s;
        pins.overTemp ##1 (!pins.overTemp && pins.clearN && !pins.outEnableN);
    endsequence

    clearSerOut_a: assert property (@(posedge clk) disable iff (!arst_n) // [R4]
        !pins.clearN |=> cascadeDataOut == 1'h0)
        else $error("Serial out not cleared.");
    serOutTake_a: assert property (@(posedge clk) disable iff (!arst_n) // [R6]
        shiftFall && pins.clearN |=> cascadeDataOut == $past(st_q.chain[sld_pkg::ChanCount-1]))
        else $error("Serial out did not take the last chain stage.");
    chainHold_a: assert property (@(posedge clk) disable iff (!arst_n) // [R2]
        pins.clearN && !shiftRise |=> st_q.chain == $past(st_q.chain))
        else $error("Shift chain moved without a rising shift edge.");
    storeOnLatch_a: assert property (@(posedge clk) disable iff (!arst_n) // [R11]
        $changed(st_q.storage) && $past(pins.clearN) |-> $past(latchRise, 2))
        else $error("Storage changed without a latch edge.");
    clearFast_a: assert property (@(posedge clk) disable iff (!arst_n) // [R15]
        $fell(clearN) |-> ##3 (st_q.chain == '0 && drainOn == '0))
        else $error("Clear did not act within three cycles.");
    thermalResume_a: assert property (@(posedge clk) disable iff (!arst_n) // [R14]
        thermalEnd_s |=> drainOn == st_q.storage)
        else $error("Drains did not resume after over-temperature.");
endmodule

// Small valid/ready FIFO carrying latched words to the output stage.
module sld_fifo #(
    parameter int Width = 12,
    parameter int Depth = 8
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             flush,
    input  wire logic [Width-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [Width-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int             AddrW  = $clog2(Depth);
    localparam logic [AddrW:0] PtrOne = {{AddrW{1'h0}}, 1'h1};

    // Pointers carry one spare bit so that full and empty differ when the indices match.
    typedef struct packed {
        logic [AddrW:0] wrPtr;
        logic [AddrW:0] rdPtr;
    } sld_fifo_state_type;

    sld_fifo_state_type fs_q;
    sld_fifo_state_type fs_d;
    logic [Width-1:0]   mem [Depth];
    logic               full;
    logic               empty;
    logic               push;
    logic               pop;

    assign empty    = fs_q.wrPtr == fs_q.rdPtr;
    assign full     = (fs_q.wrPtr[AddrW] != fs_q.rdPtr[AddrW])
                   && (fs_q.wrPtr[AddrW-1:0] == fs_q.rdPtr[AddrW-1:0]);
    assign push     = inValid && !full;
    assign pop      = !empty && outReady;
    assign inReady  = !full;
    assign outValid = !empty;
    assign outData  = mem[fs_q.rdPtr[AddrW-1:0]];

    always_comb begin
        fs_d = fs_q;
        if (flush) begin
            fs_d = '0;
        end else begin
            if (push) begin
                fs_d.wrPtr = fs_q.wrPtr + PtrOne;
            end
            if (pop) begin
                fs_d.rdPtr = fs_q.rdPtr + PtrOne;
            end
        end
    end

    // The word store needs no reset; the pointers alone say what is valid.
    always_ff @(posedge clk) begin
        if (push) begin
            mem[fs_q.wrPtr[AddrW-1:0]] <= inData;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fs_q <= '0;
        end else begin
            fs_q <= fs_d;
        end
    end

    flushEmpty_a: assert property (@(posedge clk) disable iff (!arst_n) // [R4]
        flush |=> !outValid)
        else $error("Flush left words in the FIFO.");
    pushShow_a: assert property (@(posedge clk) disable iff (!arst_n) // [R2]
        push && empty && !flush |=> outValid && outData == $past(inData))
        else $error("FIFO did not present the pushed word.");
endmodule

/* File: logic/sld_pkg.sv */
// Shared constants and carrier types for the serial LED sink driver.
// Assumes a single 100 MHz system clock domain sampling all pins.
package sld_pkg;
    localparam int              ChanCount  = 12;
    localparam int              FifoDepth  = 8;
    localparam logic [11:0]     ChainReset = 12'h000;
    localparam logic [1:0]      SyncReset  = 2'h0;

    typedef logic [ChanCount-1:0] sld_chan_type;

    // Synchronised host pins, bundled together.
    typedef struct packed {
        logic shiftClock;
        logic latchClock;
        logic clearN;
        logic serialDataIn;
        logic outEnableN;
        logic overTemp;
    } sld_pins_type;

    localparam int PinCount = 6;
endpackage

/* File: logic/sld_fifo.sv */
// This file holds no logic; the latch FIFO module is declared in sld_driver.sv.
// Nothing here needs compiling, and it declares no module of its own.

/* File: tb/sld_host_model.sv */
// Host model that drives the clock, data, clear and enable pins.
// Assumes the 100 MHz clock; pins change just after its rising edge.
`timescale 1ns/1ps
module sld_host_model (
    input  wire logic clk,
    output logic      shiftClock,
    output logic      latchClock,
    output logic      clearN,
    output logic      serialDataIn,
    output logic      outEnableN
);
    initial begin
        shiftClock = 1'h0;
        latchClock = 1'h0;
        serialDataIn = 1'h0;
        outEnableN = 1'h1;
        clearN = 1'h0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Data is inverted once its hold time runs out, so a late sample is caught.
    task automatic shift_word(input logic [11:0] w);
        for (int i = 11; i >= 0; i--) begin
            serialDataIn <= w[i];
            wt(4);
            shiftClock <= 1'h1;
            wt(4);
            serialDataIn <= ~w[i];
            wt(4);
            shiftClock <= 1'h0;
            wt(4);
        end
    endtask
    task automatic pulse_latch();
        latchClock <= 1'h1;
        wt(8);
        latchClock <= 1'h0;
        wt(8);
    endtask
    task automatic set_pins(input logic c, input logic e);
        clearN <= c;
        outEnableN <= e;
        wt(1);
    endtask
endmodule

/* File: tb/sld_driver_test.sv */
// Self-checking bench for the sink driver with a host model on its pins.
// Assumes the design answers within five clock cycles of a pin change.
`timescale 1ns/1ps
`define SLD_CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_errors++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module sld_driver_test;
    logic                  clk;
    logic                  arst_n;
    logic                  overTemp;
    logic                  shiftClock, latchClock, clearN, serialDataIn, outEnableN;
    logic                  cascadeDataOut, fifoFull, casExp = 1'h0;
    sld_pkg::sld_chan_type drainOn, expd, chain = 12'h000, store = 12'h000;
    logic [12:0]           note;
    logic [12:0]           notes[$];
    int                    n_errors = 0;
    int                    checks = 0;
    sld_driver u_dut (.clk(clk), .arst_n(arst_n), .shiftClock(shiftClock),
        .latchClock(latchClock), .clearN(clearN), .serialDataIn(serialDataIn),
        .outEnableN(outEnableN), .overTemp(overTemp), .cascadeDataOut(cascadeDataOut),
        .drainOn(drainOn), .fifoFull(fifoFull));
    sld_host_model u_host (.clk(clk), .shiftClock(shiftClock), .latchClock(latchClock),
        .clearN(clearN), .serialDataIn(serialDataIn), .outEnableN(outEnableN));
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    // Reference registers; a low clear empties them at once.
    always @(posedge shiftClock or negedge clearN)
        chain <= clearN ? {chain[10:0], serialDataIn} : 12'h000;
    always @(negedge shiftClock or negedge clearN) casExp <= clearN && chain[11];
    always @(posedge latchClock or negedge clearN) store <= clearN ? chain : 12'h000;
    // Serial out must hold across the rise and change only after the fall.
    always @(shiftClock) begin
        repeat (6) @(posedge clk);
        notes.push_back({1'h1, 11'h000, casExp});
    end
    always @(posedge clk) begin
        while (notes.size() > 0) begin
            note = notes.pop_front();
            if (note[12]) `SLD_CHK("cascadeDataOut", note[0], cascadeDataOut)
            else `SLD_CHK("drainOn", note[11:0], drainOn)
        end
    end
    task automatic note_drain();
        repeat (5) @(posedge clk);
        expd = (clearN && !outEnableN && !overTemp) ? store : 12'h000;
        notes.push_back({1'h0, expd});
    endtask
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        finish_test();
    end
    initial begin
        void'($urandom(48402));
        arst_n = 1'h0;
        overTemp = 1'h0;
        repeat (10) @(posedge clk);
        arst_n <= 1'h1;
        u_host.set_pins(1'h1, 1'h0);
        for (int k = 0; k < 4; k++) begin
            u_host.shift_word(k == 0 ? 12'h801 : 12'($urandom()));
            u_host.pulse_latch();
            note_drain();
        end
        $display("Test shift, cascade and latch done");
        for (int k = 0; k < 4; k++) begin
            u_host.set_pins(1'h1, k[0] ? 1'h0 : 1'h1);
            note_drain();
        end
        $display("Test output enable dimming done");
        overTemp <= 1'h1;
        @(posedge clk);
        note_drain();
        overTemp <= 1'h0;
        @(posedge clk);
        note_drain();
        $display("Test thermal shutdown done");
        u_host.set_pins(1'h0, 1'h0);
        note_drain();
        notes.push_back(13'h1000);
        u_host.pulse_latch();
        u_host.set_pins(1'h1, 1'h0);
        note_drain();
        u_host.pulse_latch();
        note_drain();
        `SLD_CHK("fifoFull", 1'h0, fifoFull)
        $display("Test clear done");
        repeat (20) @(posedge clk);
        finish_test();
    end
endmodule
